// file: ttep_consts.svh
// Timing counts and reset values of the touch, tap, event port and approach scan block
`ifndef TTEP_CONSTS_SVH
`define TTEP_CONSTS_SVH
`define TTEP_CLK_HZ          40000000
`define TTEP_PULSE_MS        100
`define TTEP_PULSE_CYC       ((`TTEP_CLK_HZ / 1000) * `TTEP_PULSE_MS)
`define TTEP_MS_CYC          (`TTEP_CLK_HZ / 1000)
`define TTEP_SLOW_HZ         32000
`define TTEP_SLOW_MS_TICKS   (`TTEP_SLOW_HZ / 1000)
`define TTEP_TAP_MAX_MS      1000
`define TTEP_CAL_MIN_S       2
`define TTEP_CAL_MAX_S       1024
`define TTEP_RST_TAP_MS      10'h12c
`define TTEP_RST_DTAP_MS     10'h12c
`define TTEP_RST_SCAN_MS     8'h32
`define TTEP_RST_CAL_START_S 11'h002
`define TTEP_RST_CAL_FINAL_S 11'h00a
`define TTEP_RST_CAL_TRANS_S 11'h078
`define TTEP_RST_RX_MASK     5'h01
`endif

// file: ttep_pkg.sv
// Types shared by the touch, tap, event port and approach scan block
package ttep_pkg;
	typedef enum logic [2:0] {
		TTEP_ACT_HIGH     = 3'h0,
		TTEP_ACT_LOW      = 3'h1,
		TTEP_ACT_TOGGLE   = 3'h2,
		TTEP_ACT_PULSE    = 3'h3,
		TTEP_ACT_FOLLOW_H = 3'h4,
		TTEP_ACT_FOLLOW_L = 3'h5
	} ttep_action_t;
	typedef enum logic [1:0] {
		TTEP_PM_PROCESS = 2'h0,
		TTEP_PM_SLEEP   = 2'h1,
		TTEP_PM_SCAN    = 2'h2
	} ttep_pwr_t;
	typedef enum logic [1:0] {
		TTEP_TS_IDLE    = 2'h0,
		TTEP_TS_TOUCH   = 2'h1,
		TTEP_TS_WAIT2   = 2'h2
	} ttep_tap_state_t;
endpackage

// file: ttep_tap_if.sv
// Per-electrode tap channel carrier between top and tap tracker
interface ttep_tap_if;
	logic touch;
	logic ms_tick;
	logic [9:0] tap_ms;
	logic [9:0] dtap_ms;
	logic touch_ev;
	logic short_ev;
	logic long_ev;
	logic tap_ev;
	logic dtap_ev;
	modport top (output touch, ms_tick, tap_ms, dtap_ms, input touch_ev, short_ev, long_ev, tap_ev, dtap_ev);
	modport chan (input touch, ms_tick, tap_ms, dtap_ms, output touch_ev, short_ev, long_ev, tap_ev, dtap_ev);
endinterface

// file: ttep_tap.sv
// One electrode's touch, tap and double tap tracker
module ttep_tap (
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	ttep_tap_if.chan  tp
);
	ttep_pkg::ttep_tap_state_t state, next_state;
	logic [9:0] ms_cnt, next_ms_cnt;
	logic       prev, next_prev;
	logic       dtap_pend, next_dtap_pend;
	logic       touch_ev, short_ev, long_ev, tap_ev, dtap_ev;
	logic       n_touch, n_short, n_long, n_tap, n_dtap;

	// Timer counts ms since touch onset or since the last tap release
	always_comb begin
		next_state = state;
		next_prev  = tp.touch;
		next_ms_cnt = (tp.ms_tick && ms_cnt != 10'h3ff) ? ms_cnt + 10'h001 : ms_cnt;
		n_touch = 1'b0;
		n_short = 1'b0;
		n_long  = 1'b0;
		n_tap   = 1'b0;
		n_dtap  = 1'b0;
		if (tp.touch && !prev) begin
			n_touch = 1'b1;
		end
		case (state)
			ttep_pkg::TTEP_TS_IDLE: begin
				if (tp.touch && !prev) begin
					next_state  = ttep_pkg::TTEP_TS_TOUCH;
					next_ms_cnt = 10'h000;
				end
			end
			ttep_pkg::TTEP_TS_TOUCH: begin
				if (!tp.touch) begin
					// Strictly below the window counts as a tap
					if (ms_cnt < tp.tap_ms) begin
						n_short     = 1'b1;
						n_tap       = 1'b1;
						next_state  = ttep_pkg::TTEP_TS_WAIT2;
						next_ms_cnt = 10'h000;
					end else begin
						n_long     = 1'b1;
						next_state = ttep_pkg::TTEP_TS_IDLE;
					end
				end
			end
			ttep_pkg::TTEP_TS_WAIT2: begin
				// Any new touch restarts the hold timer; a late one just cannot pair
				if (tp.touch && !prev) begin
					next_state  = ttep_pkg::TTEP_TS_TOUCH;
					next_ms_cnt = 10'h000;
				end else if (ms_cnt >= tp.dtap_ms) begin
					next_state = ttep_pkg::TTEP_TS_IDLE;
				end
			end
			default: next_state = ttep_pkg::TTEP_TS_IDLE;
		endcase
		// Double tap marks a second tap whose touch began within the interval
		if (state == ttep_pkg::TTEP_TS_TOUCH && !tp.touch && n_tap && dtap_pend) begin
			n_dtap = 1'b1;
		end
	end

	// Pending flag set by a second touch within the interval, held until that touch releases
	always_comb begin
		next_dtap_pend = dtap_pend;
		if (state == ttep_pkg::TTEP_TS_WAIT2 && tp.touch && !prev && ms_cnt < tp.dtap_ms) begin
			next_dtap_pend = 1'b1;
		end else if (state == ttep_pkg::TTEP_TS_TOUCH && !tp.touch) begin
			next_dtap_pend = 1'b0;
		end else if (state == ttep_pkg::TTEP_TS_IDLE) begin
			next_dtap_pend = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state     <= ttep_pkg::TTEP_TS_IDLE;
			ms_cnt    <= 10'h000;
			prev      <= 1'b0;
			dtap_pend <= 1'b0;
			touch_ev  <= 1'b0;
			short_ev  <= 1'b0;
			long_ev   <= 1'b0;
			tap_ev    <= 1'b0;
			dtap_ev   <= 1'b0;
		end else begin
			state     <= next_state;
			ms_cnt    <= next_ms_cnt;
			prev      <= next_prev;
			dtap_pend <= next_dtap_pend;
			touch_ev  <= n_touch;
			short_ev  <= n_short;
			long_ev   <= n_long;
			tap_ev    <= n_tap;
			dtap_ev   <= n_dtap;
		end
	end

	assign tp.touch_ev = touch_ev;
	assign tp.short_ev = short_ev;
	assign tp.long_ev  = long_ev;
	assign tp.tap_ev   = tap_ev;
	assign tp.dtap_ev  = dtap_ev;

	property p_long_no_tap;
		@(posedge i_clk) disable iff (!i_arst_n) long_ev |-> !tap_ev;
	endproperty
	a_long_no_tap: assert property (p_long_no_tap) else $error("long touch also gave tap");
	property p_dtap_with_tap;
		@(posedge i_clk) disable iff (!i_arst_n) dtap_ev |-> tap_ev && short_ev;
	endproperty
	a_dtap_with_tap: assert property (p_dtap_with_tap) else $error("double tap without a tap");
	property p_touch_onset;
		@(posedge i_clk) disable iff (!i_arst_n) $rose(tp.touch) |=> touch_ev;
	endproperty
	a_touch_onset: assert property (p_touch_onset) else $error("touch onset not reported");
endmodule

// file: ttep_top.sv
// Touch, tap, event port mapping and self wake-up approach scan scheduler
`include "ttep_consts.svh"
module ttep_top #(
	parameter int N_ELEC = 5,
	parameter int N_PINS = 5,
	parameter int PULSE_CYC = `TTEP_PULSE_CYC,
	parameter int MS_CYC = `TTEP_MS_CYC
) (
	input  wire logic               i_clk,
	input  wire logic               i_arst_n,
	input  wire logic [N_ELEC-1:0]  i_touch,
	input  wire logic [9:0]         i_tap_ms,
	input  wire logic [9:0]         i_dtap_ms,
	input  wire logic [2:0]         i_ev_sel,
	input  wire logic [2:0]         i_ev_pin,
	input  wire logic [2:0]         i_ev_action,
	input  wire logic               i_ev_en,
	input  wire logic               i_slow_oscillator,
	input  wire logic               i_approach_en,
	input  wire logic [7:0]         i_scan_ms,
	input  wire logic [N_ELEC-1:0]  i_rx_extra,
	input  wire logic [N_ELEC-1:0]  i_over_thresh,
	input  wire logic               i_host_wake_en,
	input  wire logic [10:0]        i_cal_start_s,
	input  wire logic [10:0]        i_cal_final_s,
	input  wire logic [10:0]        i_cal_trans_s,
	input  wire logic               i_scan_done,
	input  wire logic               i_external_wake_interrupt,
	input  wire logic               i_bus_start,
	input  wire logic               i_master_clear_pin_n,
	input  wire logic               i_watchdog_reset_source,
	output logic      [N_ELEC-1:0]  o_touching,
	output logic      [N_ELEC-1:0]  o_tap,
	output logic      [N_ELEC-1:0]  o_dtap,
	output logic      [N_ELEC-1:0]  o_long,
	output logic      [N_PINS-1:0]  o_event_output_pin,
	output logic      [1:0]         o_pwr_mode,
	output logic      [N_ELEC-1:0]  o_rx_active,
	output logic                    o_cal_scan,
	output logic                    o_host_wake
);
	// Five electrodes and at most eight pins fit the 3-bit selects
	if (N_ELEC != 5 || N_PINS < 1 || N_PINS > 8 || PULSE_CYC < 1 || MS_CYC < 1) begin : g_bad_param
		$error("ttep_top: unsupported parameters");
	end

	// One ms tick on the main clock for tap windows
	logic [31:0] ms_div, next_ms_div;
	logic        ms_tick;
	assign ms_tick = (ms_div == 32'(MS_CYC - 1));
	always_comb next_ms_div = ms_tick ? 32'h0 : ms_div + 32'h1;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) ms_div <= 32'h0;
		else ms_div <= next_ms_div;
	end

	// Independent tracker per electrode
	logic [N_ELEC-1:0] t_ev, s_ev, l_ev, p_ev, d_ev;
	genvar g;
	generate
		for (g = 0; g < N_ELEC; g++) begin : g_el
			ttep_tap_if tif ();
			assign tif.touch   = i_touch[g];
			assign tif.ms_tick = ms_tick;
			assign tif.tap_ms  = i_tap_ms;
			assign tif.dtap_ms = i_dtap_ms;
			assign t_ev[g] = tif.touch_ev;
			assign s_ev[g] = tif.short_ev;
			assign l_ev[g] = tif.long_ev;
			assign p_ev[g] = tif.tap_ev;
			assign d_ev[g] = tif.dtap_ev;
			ttep_tap u_tap (.i_clk(i_clk), .i_arst_n(i_arst_n), .tp(tif));
		end
	endgenerate

	// Event map: 0 touch, 1 tap, 2 double tap, 3 long, 4 approach wake
	logic [N_PINS-1:0][2:0] pin_sel, next_pin_sel, pin_act, next_pin_act;
	logic [N_PINS-1:0]      pin_on, next_pin_on;
	logic [N_PINS-1:0]      pin_lvl, next_pin_lvl;
	logic [N_PINS-1:0][31:0] pls, next_pls;
	logic [4:0]             feat_pulse, feat_level;
	logic                   wake_ev;
	assign feat_pulse = {wake_ev, |l_ev, |d_ev, |p_ev, |t_ev};
	assign feat_level = {wake_ev, |l_ev, |d_ev, |p_ev, |i_touch};

	// Config write moves a feature onto one pin, off all others
	always_comb begin
		next_pin_sel = pin_sel;
		next_pin_act = pin_act;
		next_pin_on  = pin_on;
		if (i_ev_en && 32'(i_ev_pin) < N_PINS && i_ev_sel < 3'h5) begin
			for (int k = 0; k < N_PINS; k++) begin
				if (pin_sel[k] == i_ev_sel) next_pin_on[k] = 1'b0;
			end
			next_pin_sel[i_ev_pin] = i_ev_sel;
			next_pin_act[i_ev_pin] = i_ev_action;
			next_pin_on[i_ev_pin]  = 1'b1;
		end
	end

	// Pin action on its mapped event
	always_comb begin
		next_pin_lvl = pin_lvl;
		next_pls     = pls;
		for (int k = 0; k < N_PINS; k++) begin
			if (pls[k] != 32'h0) next_pls[k] = pls[k] - 32'h1;
			if (pin_on[k]) begin
				case (ttep_pkg::ttep_action_t'(pin_act[k]))
					ttep_pkg::TTEP_ACT_HIGH:     if (feat_pulse[pin_sel[k]]) next_pin_lvl[k] = 1'b1;
					ttep_pkg::TTEP_ACT_LOW:      if (feat_pulse[pin_sel[k]]) next_pin_lvl[k] = 1'b0;
					ttep_pkg::TTEP_ACT_TOGGLE:   if (feat_pulse[pin_sel[k]]) next_pin_lvl[k] = !pin_lvl[k];
					ttep_pkg::TTEP_ACT_PULSE: begin
						// Retrigger restarts the full pulse
						if (feat_pulse[pin_sel[k]]) next_pls[k] = 32'(PULSE_CYC - 1);
						// High on the event cycle and while any count remains: PULSE_CYC cycles
						next_pin_lvl[k] = feat_pulse[pin_sel[k]] || pls[k] > 32'h0;
					end
					ttep_pkg::TTEP_ACT_FOLLOW_H: next_pin_lvl[k] = feat_level[pin_sel[k]];
					ttep_pkg::TTEP_ACT_FOLLOW_L: next_pin_lvl[k] = !feat_level[pin_sel[k]];
					default:                     next_pin_lvl[k] = pin_lvl[k];
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_sel <= '0;
			pin_act <= '0;
			pin_on  <= '0;
			pin_lvl <= '0;
			pls     <= '0;
		end else begin
			pin_sel <= next_pin_sel;
			pin_act <= next_pin_act;
			pin_on  <= next_pin_on;
			pin_lvl <= next_pin_lvl;
			pls     <= next_pls;
		end
	end

	// Slow oscillator sampled as a level; rising edge is one slow tick
	logic slow_d, slow_q;
	logic slow_tick;
	assign slow_tick = slow_d && !slow_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			slow_d <= 1'b0;
			slow_q <= 1'b0;
		end else begin
			slow_d <= i_slow_oscillator;
			slow_q <= slow_d;
		end
	end

	// Wake-up timer, ms and s prescalers on slow ticks
	ttep_pkg::ttep_pwr_t pm, next_pm;
	logic [5:0]  sl_ms, next_sl_ms;
	logic [7:0]  wk_ms, next_wk_ms;
	logic [9:0]  s_div, next_s_div;
	logic [10:0] cal_s, next_cal_s;
	logic [10:0] idle_s, next_idle_s;
	logic        cal, next_cal, host, next_host;
	logic        sec_tick, slow_ms, any_wake;
	logic [10:0] cal_iv;
	assign slow_ms  = slow_tick && (sl_ms == 6'(`TTEP_SLOW_MS_TICKS - 1));
	assign sec_tick = slow_ms && (s_div == 10'h3e7);
	// Past the transition time the final interval applies
	// Recommended 2 s, 10 s after 120 s idle come from the inputs, not from here
	assign cal_iv   = (idle_s >= i_cal_trans_s) ? i_cal_final_s : i_cal_start_s;
	assign any_wake = i_external_wake_interrupt || i_bus_start || !i_master_clear_pin_n ||
			i_watchdog_reset_source;
	assign wake_ev  = (pm == ttep_pkg::TTEP_PM_SCAN) && i_scan_done && |(i_over_thresh & o_rx_active) && !cal;

	always_comb begin
		next_pm     = pm;
		next_sl_ms  = slow_tick ? (slow_ms ? 6'h0 : sl_ms + 6'h1) : sl_ms;
		next_s_div  = slow_ms ? (sec_tick ? 10'h0 : s_div + 10'h1) : s_div;
		next_wk_ms  = wk_ms;
		next_cal_s  = (sec_tick && cal_s != 11'h7ff) ? cal_s + 11'h1 : cal_s;
		next_idle_s = (sec_tick && idle_s != 11'h7ff) ? idle_s + 11'h1 : idle_s;
		next_cal    = cal;
		next_host   = host;
		case (pm)
			ttep_pkg::TTEP_PM_PROCESS: begin
				next_host = 1'b0;
				if (i_approach_en && !(|i_touch)) begin
					next_pm     = ttep_pkg::TTEP_PM_SLEEP;
					next_wk_ms  = 8'h0;
					next_idle_s = 11'h0;
					next_cal_s  = 11'h0;
				end
			end
			ttep_pkg::TTEP_PM_SLEEP: begin
				if (slow_ms) next_wk_ms = wk_ms + 8'h1;
				if (any_wake || !i_approach_en) begin
					next_pm = ttep_pkg::TTEP_PM_PROCESS;
				end else if (slow_ms && wk_ms + 8'h1 >= i_scan_ms) begin
					next_pm  = ttep_pkg::TTEP_PM_SCAN;
					next_cal = (cal_s >= cal_iv);
					if (cal_s >= cal_iv) next_cal_s = 11'h0;
				end
			end
			ttep_pkg::TTEP_PM_SCAN: begin
				if (any_wake || !i_approach_en) begin
					next_pm = ttep_pkg::TTEP_PM_PROCESS;
				end else if (wake_ev) begin
					next_pm   = ttep_pkg::TTEP_PM_PROCESS;
					next_host = i_host_wake_en;
				end else if (i_scan_done) begin
					next_pm    = ttep_pkg::TTEP_PM_SLEEP;
					next_wk_ms = 8'h0;
					next_cal   = 1'b0;
				end
			end
			default: next_pm = ttep_pkg::TTEP_PM_PROCESS;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pm     <= ttep_pkg::TTEP_PM_PROCESS;
			sl_ms  <= 6'h0;
			s_div  <= 10'h0;
			wk_ms  <= 8'h0;
			cal_s  <= 11'h0;
			idle_s <= 11'h0;
			cal    <= 1'b0;
			host   <= 1'b0;
		end else begin
			pm     <= next_pm;
			sl_ms  <= next_sl_ms;
			s_div  <= next_s_div;
			wk_ms  <= next_wk_ms;
			cal_s  <= next_cal_s;
			idle_s <= next_idle_s;
			cal    <= next_cal;
			host   <= next_host;
		end
	end

	// Calibration uses all channels, approach uses channel 0 plus extras
	assign o_rx_active = (pm != ttep_pkg::TTEP_PM_SCAN) ? '0 :
			cal ? {N_ELEC{1'b1}} : (N_ELEC'(`TTEP_RST_RX_MASK) | i_rx_extra);
	assign o_pwr_mode = pm;
	assign o_cal_scan = cal && (pm == ttep_pkg::TTEP_PM_SCAN);
	assign o_host_wake = host;
	assign o_event_output_pin = pin_lvl;
	assign o_touching = i_touch;
	assign o_tap  = p_ev;
	assign o_dtap = d_ev;
	assign o_long = l_ev;

	// Every pin is watched, so a randomly chosen pulse pin is always covered
	for (genvar k = 0; k < N_PINS; k++) begin : g_pulse_chk
		property p_pulse_len;
			@(posedge i_clk) disable iff (!i_arst_n)
				(pin_on[k] && pin_act[k] == 3'h3 && feat_pulse[pin_sel[k]]) |=> pin_lvl[k] [*8];
		endproperty
		a_pulse_len: assert property (p_pulse_len) else $error("pulse pin dropped early");
	end
	property p_cal_all;
		@(posedge i_clk) disable iff (!i_arst_n) o_cal_scan |-> &o_rx_active;
	endproperty
	a_cal_all: assert property (p_cal_all) else $error("calibration scan lacks channels");
	property p_wake_exit;
		@(posedge i_clk) disable iff (!i_arst_n) (wake_ev && !any_wake && i_approach_en) |=> pm == ttep_pkg::TTEP_PM_PROCESS;
	endproperty
	a_wake_exit: assert property (p_wake_exit) else $error("threshold did not wake");
	property p_ext_wake;
		@(posedge i_clk) disable iff (!i_arst_n) (pm == ttep_pkg::TTEP_PM_SLEEP && any_wake) |=> pm == ttep_pkg::TTEP_PM_PROCESS;
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("wake source ignored");
	property p_scan_rx0;
		@(posedge i_clk) disable iff (!i_arst_n) (pm == ttep_pkg::TTEP_PM_SCAN) |-> o_rx_active[0];
	endproperty
	a_scan_rx0: assert property (p_scan_rx0) else $error("default channel not active");
endmodule

// file: ttep_scan_partner.sv
// Scan front end model that ends approach scans and reports channel thresholds
module ttep_scan_partner (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic [1:0] i_pwr_mode,
	input  wire logic [3:0] i_delay,
	input  wire logic [4:0] i_thr_mask,
	output logic            o_scan_done,
	output logic [4:0]      o_over_thresh
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic [4:0] noise;
	logic       in_scan;
	assign in_scan = (i_pwr_mode == 2'h2);
	// Levels only mean something during a scan; elsewhere they wander
	assign o_over_thresh = in_scan ? i_thr_mask : noise;
	// One done pulse per scan after the chosen delay; 4'hf marks it sent
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt <= 4'h0;
			noise <= 5'h15;
			o_scan_done <= 1'b0;
		end else begin
			noise <= ~noise;
			o_scan_done <= in_scan && (cnt == i_delay);
			if (!in_scan) begin
				cnt <= 4'h0;
			end else if (cnt == i_delay) begin
				cnt <= 4'hf;
			end else if (cnt != 4'hf) begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// file: ttep_top_tb.sv
// Self-checking bench for the touch, tap, event port and approach scan block
module ttep_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PC = 8;
	localparam int MC = 4;
	localparam int SMS = 128; // Clocks per slow ms: 32 slow ticks of 4 clocks
	logic [10:0] cal_start = 11'h002;
	int         n2;
	logic       clk = 1'b0, arst_n = 1'b0, ev_en = 1'b0, slow = 1'b0, appr_en = 1'b0;
	logic [4:0] touch = 5'h00, thr_mask = 5'h00, over_thresh, touching, tap, dtap, lng, pins, rx_act;
	logic [9:0] tap_ms = 10'h003, dtap_ms = 10'h004;
	logic [2:0] ev_sel = 3'h0, ev_pin = 3'h0, ev_act = 3'h0;
	logic [3:0] src = 4'h0, delay = 4'h9;
	logic [1:0] pwr;
	logic       scan_done, cal, host_wake, wake_seen = 1'b0;
	logic [3:0] q[$];
	int         num_errors = 0, checks_done = 0, taps_seen = 0, seed = 32'h41e9, e, e2, p, r, n;
	ttep_pkg::ttep_action_t acts[4] = '{ttep_pkg::TTEP_ACT_HIGH, ttep_pkg::TTEP_ACT_LOW,
		ttep_pkg::TTEP_ACT_TOGGLE, ttep_pkg::TTEP_ACT_TOGGLE};
	logic       want[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	ttep_top #(.PULSE_CYC(PC), .MS_CYC(MC)) i_ttep_top (.i_clk(clk), .i_arst_n(arst_n), .i_touch(touch),
		.i_tap_ms(tap_ms), .i_dtap_ms(dtap_ms), .i_ev_sel(ev_sel), .i_ev_pin(ev_pin), .i_ev_action(ev_act),
		.i_ev_en(ev_en), .i_slow_oscillator(slow), .i_approach_en(appr_en), .i_scan_ms(8'h02),
		.i_rx_extra(5'h04), .i_over_thresh(over_thresh), .i_host_wake_en(1'b1), .i_cal_start_s(cal_start),
		.i_cal_final_s(11'h00a), .i_cal_trans_s(11'h078), .i_scan_done(scan_done),
		.i_external_wake_interrupt(src[0]), .i_bus_start(src[1]), .i_master_clear_pin_n(~src[2]),
		.i_watchdog_reset_source(src[3]), .o_touching(touching), .o_tap(tap), .o_dtap(dtap), .o_long(lng),
		.o_event_output_pin(pins), .o_pwr_mode(pwr), .o_rx_active(rx_act), .o_cal_scan(cal),
		.o_host_wake(host_wake));
	ttep_scan_partner i_ttep_scan_partner (.i_clk(clk), .i_arst_n(arst_n), .i_pwr_mode(pwr), .i_delay(delay),
		.i_thr_mask(thr_mask), .o_scan_done(scan_done), .o_over_thresh(over_thresh));
	// Clock, and a slow oscillator sped up so one ms is 128 cycles
	initial begin
		forever #12.5 clk = ~clk;
	end
	always begin
		repeat (2) @(posedge clk);
		#2 slow = ~slow;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%0h expected=%0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic match(input logic [3:0] got);
		logic [3:0] exp;
		exp = (q.size() > 0) ? q.pop_front() : 4'hf;
		check({4'h0, got}, {4'h0, exp});
	endtask
	// Pulse outputs taken off the note queue oldest first; taps only counted
	always @(negedge clk) begin
		if (host_wake === 1'b1) wake_seen = 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (tap[i] === 1'b1) taps_seen++;
			if (lng[i] === 1'b1) match({1'b0, 3'(i)});
			if (dtap[i] === 1'b1) match({1'b1, 3'(i)});
		end
	end
	task automatic wait_ms(input int ms);
		repeat (ms * MC) @(posedge clk);
		#2;
	endtask
	task automatic press(input int el, input int ms);
		@(posedge clk);
		#2 touch[el] = 1'b1;
		wait_ms(ms);
		touch[el] = 1'b0;
		wait_ms(12); // Outlasts the double tap interval
	endtask
	task automatic cfg(input logic [2:0] sel, input logic [2:0] pin, input logic [2:0] act);
		@(posedge clk);
		#2 {ev_sel, ev_pin, ev_act, ev_en} = {sel, pin, act, 1'b1};
		@(posedge clk);
		#2 ev_en = 1'b0;
	endtask
	// Bounded wait for a power mode; n reaches lim on a hang
	task automatic wait_mode(input logic [1:0] m, input int lim, output int cnt);
		cnt = 0;
		while (pwr !== m && cnt < lim) begin
			@(negedge clk);
			cnt++;
		end
	endtask
	initial begin
		#(25 * 60000);
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge clk);
		#2 arst_n = 1'b1;
		check({3'h0, pins}, 8'h00);
		e = $unsigned($random(seed)) % 5;
		e2 = (e + 1) % 5;
		p = $unsigned($random(seed)) % 5;
		r = (p + 2) % 5;
		// Short, long and double touches on one electrode
		press(e, 1);
		check(8'(taps_seen), 8'h01);
		q.push_back({1'b0, 3'(e)});
		press(e, 6);
		check(8'(taps_seen), 8'h01);
		q.push_back({1'b1, 3'(e)});
		@(posedge clk);
		#2 touch[e] = 1'b1;
		wait_ms(1);
		touch[e] = 1'b0;
		wait_ms(1);
		press(e, 1);
		// Two electrodes at once, one short and one long
		taps_seen = 0;
		q.push_back({1'b0, 3'(e2)});
		@(posedge clk);
		#2 touch = (5'h01 << e) | (5'h01 << e2);
		wait_ms(1);
		check({3'h0, touching}, {3'h0, touch});
		touch[e] = 1'b0;
		wait_ms(5);
		touch[e2] = 1'b0;
		wait_ms(12);
		check(8'(taps_seen), 8'h01);
		// Zero tap window leaves every touch long
		tap_ms = 10'h000;
		q.push_back({1'b0, 3'(e)});
		press(e, 1);
		check(8'(taps_seen), 8'h01);
		tap_ms = 10'h003;
		// Pin actions driven by taps, follow actions by touch level
		for (int k = 0; k < 4; k++) begin
			if (k < 3) cfg(3'h1, 3'(p), acts[k]);
			press(e, 1);
			check({3'h0, pins}, {3'h0, 5'(want[k]) << p});
		end
		cfg(3'h1, 3'(r), ttep_pkg::TTEP_ACT_TOGGLE);
		press(e, 1);
		check({3'h0, pins}, {3'h0, 5'h01 << r});
		cfg(3'h1, 3'h5, ttep_pkg::TTEP_ACT_HIGH);
		cfg(3'h5, 3'(r), ttep_pkg::TTEP_ACT_HIGH);
		press(e, 1);
		check({3'h0, pins}, 8'h00);
		cfg(3'h1, 3'(r), ttep_pkg::TTEP_ACT_PULSE);
		@(posedge clk);
		#2 touch[e] = 1'b1;
		wait_ms(1);
		touch[e] = 1'b0;
		n = 0;
		while (pins[r] !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (pins[r] === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check(8'(n), 8'(PC));
		wait_ms(12);
		for (int k = 4; k < 6; k++) begin
			cfg(3'h0, 3'(p), 3'(k));
			@(posedge clk);
			#2 touch[e] = 1'b1;
			wait_ms(1);
			check({7'h0, pins[p]}, {7'h0, k == 4});
			touch[e] = 1'b0;
			wait_ms(1);
			check({7'h0, pins[p]}, {7'h0, k == 5});
			wait_ms(12);
		end
		// Approach detection: sleep length, scan channels, thresholds
		q.delete();
		appr_en = 1'b1;
		wait_mode(2'h1, 50, n);
		check({6'h0, pwr}, 8'h01);
		wait_mode(2'h2, 300, n);
		check({3'h0, rx_act}, 8'h05);
		// Scans start on slow ms boundaries, so the start-to-start gap is exact
		wait_mode(2'h1, 50, n);
		wait_mode(2'h2, 300, n2);
		check(8'(n + n2 == 2 * SMS), 8'h01);
		@(posedge clk);
		#2 thr_mask = 5'h10;
		wait_mode(2'h1, 50, n);
		check(8'(n < 50), 8'h01);
		@(posedge clk);
		#2 {thr_mask, delay} = {5'h04, 4'h0};
		wait_wake: begin
			wait_mode(2'h2, 1000, n);
			wait_mode(2'h0, 20, n);
		end
		check(8'(n < 20), 8'h01);
		@(negedge clk);
		check({7'h0, wake_seen}, 8'h01);
		@(posedge clk);
		#2 thr_mask = 5'h00;
		// Each outside wake source returns the block to processing
		for (int k = 0; k < 4; k++) begin
			wait_mode(2'h1, 50, n);
			repeat (3) @(posedge clk);
			#2 src = 4'h1 << k;
			wait_mode(2'h0, 10, n);
			check(8'(n < 10), 8'h01);
			@(posedge clk);
			#2 src = 4'h0;
		end
		// Zero start interval makes the next scan a calibration scan
		cal_start = 11'h000;
		wait_mode(2'h2, 400, n);
		check({7'h0, cal}, 8'h01);
		check({3'h0, rx_act}, 8'h1f);
		check(8'(q.size()), 8'h00);
		print_verdict();
	end
endmodule
